// ===== hw/ulpd_defines.svh
`ifndef ULPD_DEFINES_SVH
`define ULPD_DEFINES_SVH

// ----------------------------------------
// register map
// ----------------------------------------
`define ULPD_ADDR_W         32
`define ULPD_DATA_W         16
`define ULPD_OFF_DIV_LOW    32'h5000_1020
`define ULPD_OFF_DIV_HIGH   32'h5000_1024
`define ULPD_DIV_RESET      8'h00

// ----------------------------------------
// baud generation
// ----------------------------------------
`define ULPD_OVERSAMPLE     16
`define ULPD_OVS_W          4

`endif

// ===== hw/ulpd_pkg.sv
`include "ulpd_defines.svh"

package ulpd_pkg;

  // ----------------------------------------
  // register bus request
  // ----------------------------------------
  typedef struct packed {
    logic [`ULPD_ADDR_W-1:0] addr;
    logic [`ULPD_DATA_W-1:0] wdata;
    logic                    wr;
    logic                    rd;
  } ulpd_req_t;

  typedef enum logic [1:0] {
    ULPD_ST_OFF = 2'b01,
    ULPD_ST_RUN = 2'b10
  } ulpd_state_t;

endpackage : ulpd_pkg

// ===== hw/ulpd_tick_div.sv
`timescale 1ns/100ps
`include "ulpd_defines.svh"

// divides by a programmable count; enable pulse when the count wraps
module ulpd_tick_div
  import ulpd_pkg::*;
#(
  parameter int W = 16
)
(
  // clock and reset
  input  wire logic         core_clk,
  input  wire logic         rst_n,
  // control
  input  wire logic         run,
  input  wire logic [W-1:0] count,
  // tick
  output logic              tick
);

  logic [W-1:0] cnt_q;

  // restart on every stop so a new divisor takes effect cleanly
  always_ff @(posedge core_clk)
  begin
    if (!rst_n || !run)
    begin
      cnt_q <= '0;
      tick  <= 1'b0;
    end
    else if (cnt_q >= count - W'(1))
    begin
      cnt_q <= '0;
      tick  <= 1'b1;
    end
    else
    begin
      cnt_q <= cnt_q + W'(1);
      tick  <= 1'b0;
    end
  end

endmodule : ulpd_tick_div

// ===== hw/ulpd_divisor.sv
// The address-and-strobe port was chosen for this implementation.
`timescale 1ns/100ps
`include "ulpd_defines.svh"

module ulpd_divisor
  import ulpd_pkg::*;
#(
  parameter int DIV_W = 16
)
(
  // clock and reset
  input  wire logic                   core_clk,
  input  wire logic                   rst_n,
  // register port
  input  wire ulpd_req_t              bus_req,
  output logic [`ULPD_DATA_W-1:0]     rdata_q,
  // line control
  input  wire logic                   divisor_latch_access,
  input  wire logic                   infrared_serial_mode,
  // receiver side
  output logic                        lowpower_baud_tick,
  output logic                        pulse_detect_en,
  output logic [DIV_W-1:0]            lowpower_divisor
);

  // ----------------------------------------
  // divisor bytes
  // ----------------------------------------
  logic [7:0]  lowpower_div_low_q;
  logic [7:0]  lowpower_div_high_q;
  logic        sel_low;
  logic        sel_high;
  ulpd_state_t state_q;
  logic        ovs_tick;
  logic [`ULPD_OVS_W-1:0] ovs_q;

  assign sel_low  = bus_req.addr == `ULPD_OFF_DIV_LOW;
  assign sel_high = bus_req.addr == `ULPD_OFF_DIV_HIGH;
  assign lowpower_divisor = {lowpower_div_high_q, lowpower_div_low_q};

  // writes gated by the access bit; others are dropped silently
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      lowpower_div_low_q  <= `ULPD_DIV_RESET;
      lowpower_div_high_q <= `ULPD_DIV_RESET;
    end
    else if (bus_req.wr && divisor_latch_access)
    begin
      if (sel_low)
        lowpower_div_low_q <= bus_req.wdata[7:0];
      if (sel_high)
        lowpower_div_high_q <= bus_req.wdata[7:0];
    end
  end

  // reads outside the access window, or unmapped, return zero
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
      rdata_q <= '0;
    else if (bus_req.rd && divisor_latch_access && sel_low)
      rdata_q <= {8'h00, lowpower_div_low_q};
    else if (bus_req.rd && divisor_latch_access && sel_high)
      rdata_q <= {8'h00, lowpower_div_high_q};
    else
      rdata_q <= '0;
  end

  // ----------------------------------------
  // run control
  // ----------------------------------------
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
      state_q <= ULPD_ST_OFF;
    else
    begin
      case (state_q)
        ULPD_ST_OFF: if (lowpower_divisor != '0) state_q <= ULPD_ST_RUN;
        ULPD_ST_RUN: if (lowpower_divisor == '0) state_q <= ULPD_ST_OFF;
        default:     state_q <= ULPD_ST_OFF;
      endcase
    end
  end

  // ----------------------------------------
  // baud generation: divisor, then by sixteen
  // ----------------------------------------
  ulpd_tick_div #(.W(DIV_W)) u_div (
    .core_clk (core_clk),
    .rst_n    (rst_n),
    .run      (state_q == ULPD_ST_RUN),
    .count    (lowpower_divisor),
    .tick     (ovs_tick)
  );

  always_ff @(posedge core_clk)
  begin
    if (!rst_n || state_q != ULPD_ST_RUN)
    begin
      ovs_q              <= '0;
      lowpower_baud_tick <= 1'b0;
    end
    else
    begin
      if (ovs_tick)
        ovs_q <= ovs_q + `ULPD_OVS_W'(1);
      lowpower_baud_tick <= ovs_tick && (ovs_q == `ULPD_OVS_W'(`ULPD_OVERSAMPLE - 1));
    end
  end

  // receiver detection only with a running clock
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
      pulse_detect_en <= 1'b0;
    else
      pulse_detect_en <= infrared_serial_mode && (state_q == ULPD_ST_RUN);
  end

  // ----------------------------------------
  // checks
  // ----------------------------------------
  logic [DIV_W+4:0] gap_q;
  logic             gap_ok_q;
  logic [DIV_W-1:0] div_seen_q;

  always_ff @(posedge core_clk)
  begin
    if (!rst_n || lowpower_baud_tick || state_q != ULPD_ST_RUN)
      gap_q <= '0;
    else
      gap_q <= gap_q + (DIV_W+5)'(1);
  end

  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
      div_seen_q <= '0;
    else
      div_seen_q <= lowpower_divisor;
  end

  // first period after a start or a divisor change is not a full one
  always_ff @(posedge core_clk)
  begin
    if (!rst_n || state_q != ULPD_ST_RUN || lowpower_divisor != div_seen_q)
      gap_ok_q <= 1'b0;
    else if (lowpower_baud_tick)
      gap_ok_q <= 1'b1;
  end

  chk_div_blocked: assert property (@(posedge core_clk) disable iff (!rst_n)
    (bus_req.wr && !divisor_latch_access) |=> $stable(lowpower_divisor))
    else $error("divisor changed without access bit");
  chk_div_write: assert property (@(posedge core_clk) disable iff (!rst_n)
    (bus_req.wr && divisor_latch_access && sel_low)
      |=> lowpower_div_low_q == $past(bus_req.wdata[7:0]))
    else $error("low byte write lost");
  chk_read_back: assert property (@(posedge core_clk) disable iff (!rst_n)
    (bus_req.rd && divisor_latch_access && sel_high && !bus_req.wr)
      |=> rdata_q == {8'h00, lowpower_div_high_q})
    else $error("high byte read mismatch");
  chk_read_gated: assert property (@(posedge core_clk) disable iff (!rst_n)
    (bus_req.rd && !divisor_latch_access) |=> rdata_q == '0)
    else $error("read without access bit not zero");
  chk_zero_off: assert property (@(posedge core_clk) disable iff (!rst_n)
    (lowpower_divisor == '0) |=> ##1 (!lowpower_baud_tick && !pulse_detect_en))
    else $error("zero divisor still running");
  chk_tick_gap: assert property (@(posedge core_clk) disable iff (!rst_n)
    (lowpower_baud_tick && gap_ok_q) |-> gap_q + (DIV_W+5)'(1) ==
      (DIV_W+5)'(`ULPD_OVERSAMPLE) * (DIV_W+5)'(lowpower_divisor) || !$stable(lowpower_divisor))
    else $error("baud period wrong");
  chk_tick_single: assert property (@(posedge core_clk) disable iff (!rst_n)
    (lowpower_baud_tick && lowpower_divisor != 16'h0001) |=> !lowpower_baud_tick)
    else $error("baud tick too long");
  chk_detect_mode: assert property (@(posedge core_clk) disable iff (!rst_n)
    pulse_detect_en |-> $past(infrared_serial_mode))
    else $error("detection without infrared mode");
  chk_high_write: assert property (@(posedge core_clk) disable iff (!rst_n)
    (bus_req.wr && divisor_latch_access && sel_high)
      |=> lowpower_div_high_q == $past(bus_req.wdata[7:0]))
    else $error("high byte write lost");
  chk_low_kept: assert property (@(posedge core_clk) disable iff (!rst_n)
    (bus_req.wr && sel_high) |=> $stable(lowpower_div_low_q))
    else $error("high byte write disturbed low byte");
  chk_read_low: assert property (@(posedge core_clk) disable iff (!rst_n)
    (bus_req.rd && divisor_latch_access && sel_low && !bus_req.wr)
      |=> rdata_q == {8'h00, lowpower_div_low_q})
    else $error("low byte read mismatch");
  chk_read_once: assert property (@(posedge core_clk) disable iff (!rst_n)
    !bus_req.rd |=> rdata_q == '0)
    else $error("read data held past its cycle");
  chk_run_follows: assert property (@(posedge core_clk) disable iff (!rst_n)
    (lowpower_divisor != '0) |=> state_q == ULPD_ST_RUN)
    else $error("nonzero divisor not running");
  chk_tick_run: assert property (@(posedge core_clk) disable iff (!rst_n)
    lowpower_baud_tick |-> $past(state_q == ULPD_ST_RUN))
    else $error("baud tick while stopped");
  chk_detect_on: assert property (@(posedge core_clk) disable iff (!rst_n)
    (infrared_serial_mode && state_q == ULPD_ST_RUN) |=> pulse_detect_en)
    else $error("detection not enabled in infrared mode");

  cov_write_low: cover property (@(posedge core_clk) disable iff (!rst_n)
    bus_req.wr && divisor_latch_access && sel_low);
  cov_blocked: cover property (@(posedge core_clk) disable iff (!rst_n)
    bus_req.wr && !divisor_latch_access && sel_high);
  cov_tick: cover property (@(posedge core_clk) disable iff (!rst_n) lowpower_baud_tick);
  cov_stop: cover property (@(posedge core_clk) disable iff (!rst_n)
    state_q == ULPD_ST_RUN ##1 state_q == ULPD_ST_OFF);
  cov_detect: cover property (@(posedge core_clk) disable iff (!rst_n) pulse_detect_en);

endmodule : ulpd_divisor

// ===== test/uart_low_power_divisor_tb_top.sv
`timescale 1ns/100ps
`include "ulpd_defines.svh"

module uart_low_power_divisor_tb_top
  import ulpd_pkg::*;
;
  // ----------------------------------------
  // stimulus and bookkeeping
  // ----------------------------------------
  localparam logic [31:0] A_LO = `ULPD_OFF_DIV_LOW;
  localparam logic [31:0] A_HI = `ULPD_OFF_DIV_HIGH;
  logic        core_clk;
  logic        rst_n;
  logic        access;
  logic        ir_mode;
  logic        tick;
  logic        pd_en;
  logic        rd_prev;
  ulpd_req_t   req;
  logic [15:0] rdata;
  logic [15:0] div;
  logic [15:0] expq[$];
  logic [31:0] r;
  int          n_mismatch;
  int          checks;
  int          seed;
  int          n;

  ulpd_divisor dut
  (
    .core_clk             (core_clk),
    .rst_n                (rst_n),
    .bus_req              (req),
    .rdata_q              (rdata),
    .divisor_latch_access (access),
    .infrared_serial_mode (ir_mode),
    .lowpower_baud_tick   (tick),
    .pulse_detect_en      (pd_en),
    .lowpower_divisor     (div)
  );

  task cmp(input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : cmp

  task conclude;
    $display("mismatches %0d checks %0d", n_mismatch, checks);
    if (n_mismatch == 0 && checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : conclude

  // one strobe per call; the next call or idle clears it a cycle later
  task op(input logic w, input logic [31:0] a, input logic [15:0] d, input logic [15:0] x);
    @(posedge core_clk);
    req <= '{addr: a, wdata: d, wr: w, rd: !w};
    if (!w)
      expq.push_back(x);
  endtask : op

  task idle;
    @(posedge core_clk);
    req.wr <= 1'b0;
    req.rd <= 1'b0;
  endtask : idle

  // upper wdata bits random: only the low byte of each write counts
  task set_div(input logic [15:0] v);
    r = $random(seed);
    op(1'b1, A_LO, {r[15:8], v[7:0]}, 16'h0);
    op(1'b1, A_HI, {r[7:0], v[15:8]}, 16'h0);
    idle();
    @(negedge core_clk);
    cmp(div, v);
    repeat (8) @(posedge core_clk);
  endtask : set_div

  task meas(input int x);
    n = 0;
    while (tick !== 1'b1 && n < 5000)
    begin
      @(posedge core_clk);
      n++;
    end
    n = 0;
    do
    begin
      @(posedge core_clk);
      n++;
    end while (tick !== 1'b1 && n < 5000);
    cmp(n[15:0], x[15:0]);
  endtask : meas

  // ----------------------------------------
  // clock, monitor, watchdog, sequence
  // ----------------------------------------
  initial
  begin
    core_clk = 1'b0;
    forever #25 core_clk = ~core_clk;
  end

  always @(posedge core_clk)
  begin
    if (rd_prev)
      cmp(rdata, expq.pop_front());
    rd_prev <= req.rd;
  end

  initial
  begin
    #1000000;
    n_mismatch++;
    conclude();
  end

  initial
  begin
    seed = 32'he5ee27d9;
    req = '0;
    access = 1'b1;
    ir_mode = 1'b0;
    rst_n = 1'b0;
    rd_prev = 1'b0;
    repeat (2) @(posedge core_clk);
    rst_n <= 1'b1;
    op(1'b0, A_LO, 16'h0, 16'h0000);
    op(1'b0, A_HI, 16'h0, 16'h0000);
    set_div($random(seed));
    cmp({15'h0, pd_en}, 16'h0000);
    r = {16'h0, div};
    op(1'b0, A_LO, 16'h0, {8'h00, r[7:0]});
    op(1'b0, A_HI, 16'h0, {8'h00, r[15:8]});
    op(1'b1, A_HI + 32'h4, 16'h00ff, 16'h0);
    op(1'b0, A_HI + 32'h4, 16'h0, 16'h0000);
    op(1'b0, A_HI, 16'h0, {8'h00, r[15:8]});
    idle();
    access <= 1'b0;
    op(1'b1, A_LO, ~r[15:0], 16'h0);
    op(1'b0, A_LO, 16'h0, 16'h0000);
    idle();
    access <= 1'b1;
    op(1'b0, A_LO, 16'h0, {8'h00, r[7:0]});
    idle();
    set_div(16'h0000);
    ir_mode <= 1'b1;
    set_div(16'h0003);
    meas(48);
    cmp({15'h0, pd_en}, 16'h0001);
    // nearest divisor to 115.2 kBd from the 20 MHz clock
    set_div(16'h000b);
    meas(176);
    set_div(16'h0100);
    meas(4096);
    set_div(16'h0000);
    repeat (3) @(posedge core_clk);
    n = 0;
    repeat (100)
    begin
      @(posedge core_clk);
      n += (tick !== 1'b0 || pd_en !== 1'b0);
    end
    cmp(n[15:0], 16'h0000);
    repeat (3) @(posedge core_clk);
    conclude();
  end
endmodule : uart_low_power_divisor_tb_top
